// [design/odcr_pkg.sv]
`default_nettype none
package odcr_pkg;
   // ************************************************************
   // register offsets
   // ************************************************************
   localparam logic [7:0] MARGIN_OFFSET_HIGH_OFS        = 8'h10;
   localparam logic [7:0] MARGIN_OFFSET_LOW_OFS         = 8'h11;
   localparam logic [7:0] OUTPUT_DRIVER_CONTROL_OFS     = 8'h15;
   localparam logic [7:0] OUTPUT_DIVIDER_HIGH_OFS       = 8'h16;
   localparam logic [7:0] OUTPUT_DIVIDER_LOW_OFS        = 8'h17;
   localparam logic [7:0] REFERENCE_DIVIDER_CONTROL_OFS = 8'h18;
   localparam logic [7:0] FEEDBACK_INTEGER_HIGH_OFS     = 8'h19;
   localparam logic [7:0] FEEDBACK_INTEGER_LOW_OFS      = 8'h1a;
   localparam logic [7:0] FRACTION_NUMERATOR_BYTE2_OFS  = 8'h1b;
   localparam logic [7:0] FRACTION_NUMERATOR_BYTE1_OFS  = 8'h1c;

   // ************************************************************
   // field positions and widths
   // ************************************************************
   localparam int          MARGIN_W           = 10;
   localparam int          OUT_DIV_W          = 9;
   localparam int          FB_INT_W           = 12;
   localparam int          FRAC_HI_W          = 14;
   localparam int          PWRDN_BIT          = 7;
   localparam logic [8:0]  OUT_DIV_MIN        = 9'h005;

   // ************************************************************
   // reset values and driver select encodings
   // ************************************************************
   localparam logic [1:0]  MARGIN_HIGH_RST    = 2'h0;
   localparam logic [7:0]  MARGIN_LOW_RST     = 8'h00;
   localparam logic        PWRDN_RST          = 1'b0;
   localparam logic [1:0]  OUT_SEL_TRISTATE   = 2'h0;
   localparam logic [1:0]  OUT_SEL_LVPECL     = 2'h1;
   localparam logic [1:0]  OUT_SEL_LVDS       = 2'h2;
   localparam logic [1:0]  OUT_SEL_HCSL       = 2'h3;
   localparam logic        OUT_DIV_HIGH_RST   = 1'b0;
   localparam logic [7:0]  OUT_DIV_LOW_RST    = 8'h46;
   localparam logic        RDIV4_RST          = 1'b0;
   localparam logic [3:0]  FB_INT_HIGH_RST    = 4'h0;
   localparam logic [7:0]  FB_INT_LOW_RST     = 8'h31;
   localparam logic [5:0]  FRAC_BYTE2_RST     = 6'h00;
   localparam logic [7:0]  FRAC_BYTE1_RST     = 8'h01;

   // ************************************************************
   // serial port
   // ************************************************************
   localparam logic [2:0]  LAST_BIT           = 3'h7;

   typedef enum logic [3:0] {
      ODCR_IDLE     = 4'b0000,
      ODCR_ADDR     = 4'b0001,
      ODCR_ADDR_ACK = 4'b0010,
      ODCR_REG      = 4'b0011,
      ODCR_REG_ACK  = 4'b0100,
      ODCR_WR       = 4'b0101,
      ODCR_WR_ACK   = 4'b0110,
      ODCR_RD       = 4'b0111,
      ODCR_RD_ACK   = 4'b1000
   } odcr_state_t;
endpackage : odcr_pkg
`default_nettype wire

// [design/odcr_regs.sv]
`timescale 1ns/1ns
`default_nettype none
module odcr_regs
   import odcr_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h5a  // arbitrary bus address
) (
   input  wire logic                 i_clk_sys,
   input  wire logic                 i_sys_rst,
   input  wire logic                 i_scl,
   input  wire logic                 i_sda,
   output logic                      o_sda,
   output logic                      o_sda_oe,
   output logic [MARGIN_W-1:0]       o_crystal_margin_offset,
   output logic                      o_diff_buffer_powerdown,
   output logic [1:0]                o_out_sel,
   output logic [OUT_DIV_W-1:0]      o_out_div,
   output logic                      o_out_div_reserved,
   output logic                      o_reference_div4_enable,
   output logic [FB_INT_W-1:0]       o_feedback_integer_value,
   output logic [FRAC_HI_W-1:0]      o_fraction_numerator_high
);

   // ************************************************************
   // pin synchronisers and edge detect
   // ************************************************************
   logic        scl_s1_reg, scl_s2_reg, scl_d_reg;
   logic        sda_s1_reg, sda_s2_reg, sda_d_reg;
   logic        scl_rise, scl_fall, bus_start, bus_stop;

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         scl_s1_reg <= 1'b1;
         scl_s2_reg <= 1'b1;
         scl_d_reg  <= 1'b1;
         sda_s1_reg <= 1'b1;
         sda_s2_reg <= 1'b1;
         sda_d_reg  <= 1'b1;
      end else begin
         scl_s1_reg <= i_scl;
         scl_s2_reg <= scl_s1_reg;
         scl_d_reg  <= scl_s2_reg;
         sda_s1_reg <= i_sda;
         sda_s2_reg <= sda_s1_reg;
         sda_d_reg  <= sda_s2_reg;
      end
   end

   assign scl_rise  = scl_s2_reg & ~scl_d_reg;
   assign scl_fall  = ~scl_s2_reg & scl_d_reg;
   assign bus_start = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
   assign bus_stop  = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;

   // ************************************************************
   // register storage
   // ************************************************************
   logic [1:0]  margin_high_reg;
   logic [7:0]  margin_low_reg;
   logic        pwrdn_reg;
   logic [1:0]  out_sel_reg;
   logic        out_div_high_reg;
   logic [7:0]  out_div_low_reg;
   logic        rdiv4_reg;
   logic [3:0]  fb_int_high_reg;
   logic [7:0]  fb_int_low_reg;
   logic [5:0]  frac_byte2_reg;
   logic [7:0]  frac_byte1_reg;

   // reserved bits read as zero
   function automatic logic [7:0] reg_read(input logic [7:0] addr);
      logic [7:0] rd;
      rd = 8'h00;
      unique case (addr)
         MARGIN_OFFSET_HIGH_OFS:        rd = {6'h00, margin_high_reg};
         MARGIN_OFFSET_LOW_OFS:         rd = margin_low_reg;
         OUTPUT_DRIVER_CONTROL_OFS:     rd = {pwrdn_reg, 5'h00, out_sel_reg};
         OUTPUT_DIVIDER_HIGH_OFS:       rd = {7'h00, out_div_high_reg};
         OUTPUT_DIVIDER_LOW_OFS:        rd = out_div_low_reg;
         REFERENCE_DIVIDER_CONTROL_OFS: rd = {7'h00, rdiv4_reg};
         FEEDBACK_INTEGER_HIGH_OFS:     rd = {4'h0, fb_int_high_reg};
         FEEDBACK_INTEGER_LOW_OFS:      rd = fb_int_low_reg;
         FRACTION_NUMERATOR_BYTE2_OFS:  rd = {2'h0, frac_byte2_reg};
         FRACTION_NUMERATOR_BYTE1_OFS:  rd = frac_byte1_reg;
         default:                       rd = 8'h00;
      endcase
      return rd;
   endfunction : reg_read

   // ************************************************************
   // serial protocol engine
   // ************************************************************
   odcr_state_t state_reg;
   logic [2:0]  bit_cnt_reg;
   logic [7:0]  shift_reg;
   logic        sda_low_reg;
   logic        rw_reg;
   logic        nack_reg;
   logic [7:0]  ptr_reg;
   logic        last_bit;
   logic        wr_fire;
   logic        ptr_load;
   logic        rd_load;
   logic        rise_seen_reg;
   logic        bit_end;
   logic [7:0]  rd_byte;

   // a bit ends on a fall after a rise; skips the fall that closes a start
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         rise_seen_reg <= 1'b0;
      end else if (bus_start) begin
         rise_seen_reg <= 1'b0;
      end else if (scl_rise) begin
         rise_seen_reg <= 1'b1;
      end else if (scl_fall) begin
         rise_seen_reg <= 1'b0;
      end
   end

   always_comb begin
      rd_byte = reg_read(ptr_reg);
   end

   assign bit_end  = scl_fall & rise_seen_reg;
   assign last_bit = (bit_cnt_reg == LAST_BIT);
   assign wr_fire  = bit_end & (state_reg == ODCR_WR) & last_bit;
   assign ptr_load = bit_end & (state_reg == ODCR_REG) & last_bit;
   assign rd_load  = bit_end & (((state_reg == ODCR_ADDR_ACK) & rw_reg)
                              | ((state_reg == ODCR_RD_ACK) & ~nack_reg));

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         state_reg   <= ODCR_IDLE;
         bit_cnt_reg <= 3'h0;
         shift_reg   <= 8'h00;
         sda_low_reg <= 1'b0;
         rw_reg      <= 1'b0;
         nack_reg    <= 1'b0;
      end else if (bus_start) begin
         state_reg   <= ODCR_ADDR;
         bit_cnt_reg <= 3'h0;
         sda_low_reg <= 1'b0;
      end else if (bus_stop) begin
         state_reg   <= ODCR_IDLE;
         sda_low_reg <= 1'b0;
      end else if (scl_rise) begin
         if (state_reg == ODCR_ADDR || state_reg == ODCR_REG || state_reg == ODCR_WR) begin
            shift_reg <= {shift_reg[6:0], sda_s2_reg};
         end
         if (state_reg == ODCR_RD_ACK) begin
            nack_reg <= sda_s2_reg;
         end
      end else if (bit_end) begin
         unique case (state_reg)
            ODCR_IDLE: begin
               sda_low_reg <= 1'b0;
            end
            ODCR_ADDR, ODCR_REG, ODCR_WR: begin
               bit_cnt_reg <= bit_cnt_reg + 3'h1;
               if (last_bit) begin
                  if (state_reg == ODCR_ADDR && shift_reg[7:1] != DEV_ADDR) begin
                     state_reg <= ODCR_IDLE;
                  end else begin
                     sda_low_reg <= 1'b1;
                     if (state_reg == ODCR_ADDR) begin
                        rw_reg    <= shift_reg[0];
                        state_reg <= ODCR_ADDR_ACK;
                     end else if (state_reg == ODCR_REG) begin
                        state_reg <= ODCR_REG_ACK;
                     end else begin
                        state_reg <= ODCR_WR_ACK;
                     end
                  end
               end
            end
            ODCR_ADDR_ACK, ODCR_RD_ACK: begin
               bit_cnt_reg <= 3'h0;
               if (rd_load) begin
                  shift_reg   <= rd_byte;
                  sda_low_reg <= ~rd_byte[7];
                  state_reg   <= ODCR_RD;
               end else begin
                  sda_low_reg <= 1'b0;
                  state_reg   <= (state_reg == ODCR_RD_ACK) ? ODCR_IDLE : ODCR_REG;
               end
            end
            ODCR_REG_ACK, ODCR_WR_ACK: begin
               bit_cnt_reg <= 3'h0;
               sda_low_reg <= 1'b0;
               state_reg   <= ODCR_WR;
            end
            ODCR_RD: begin
               bit_cnt_reg <= bit_cnt_reg + 3'h1;
               if (last_bit) begin
                  sda_low_reg <= 1'b0;
                  state_reg   <= ODCR_RD_ACK;
               end else begin
                  shift_reg   <= {shift_reg[6:0], 1'b0};
                  sda_low_reg <= ~shift_reg[6];
               end
            end
            default: begin
               state_reg   <= ODCR_IDLE;
               sda_low_reg <= 1'b0;
            end
         endcase
      end
   end

   // ************************************************************
   // register pointer, auto increment
   // ************************************************************
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         ptr_reg <= 8'h00;
      end else if (ptr_load) begin
         ptr_reg <= shift_reg;
      end else if (wr_fire || rd_load) begin
         ptr_reg <= ptr_reg + 8'h01;
      end
   end

   // ************************************************************
   // register writes
   // ************************************************************
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         margin_high_reg  <= MARGIN_HIGH_RST;
         margin_low_reg   <= MARGIN_LOW_RST;
         pwrdn_reg        <= PWRDN_RST;
         out_sel_reg      <= OUT_SEL_LVPECL;
         out_div_high_reg <= OUT_DIV_HIGH_RST;
         out_div_low_reg  <= OUT_DIV_LOW_RST;
         rdiv4_reg        <= RDIV4_RST;
         fb_int_high_reg  <= FB_INT_HIGH_RST;
         fb_int_low_reg   <= FB_INT_LOW_RST;
         frac_byte2_reg   <= FRAC_BYTE2_RST;
         frac_byte1_reg   <= FRAC_BYTE1_RST;
      end else if (wr_fire) begin
         unique case (ptr_reg)
            MARGIN_OFFSET_HIGH_OFS:        margin_high_reg  <= shift_reg[1:0];
            MARGIN_OFFSET_LOW_OFS:         margin_low_reg   <= shift_reg;
            OUTPUT_DRIVER_CONTROL_OFS: begin
               pwrdn_reg   <= shift_reg[PWRDN_BIT];
               out_sel_reg <= shift_reg[1:0];
            end
            OUTPUT_DIVIDER_HIGH_OFS:       out_div_high_reg <= shift_reg[0];
            OUTPUT_DIVIDER_LOW_OFS:        out_div_low_reg  <= shift_reg;
            REFERENCE_DIVIDER_CONTROL_OFS: rdiv4_reg        <= shift_reg[0];
            FEEDBACK_INTEGER_HIGH_OFS:     fb_int_high_reg  <= shift_reg[3:0];
            FEEDBACK_INTEGER_LOW_OFS:      fb_int_low_reg   <= shift_reg;
            FRACTION_NUMERATOR_BYTE2_OFS:  frac_byte2_reg   <= shift_reg[5:0];
            FRACTION_NUMERATOR_BYTE1_OFS:  frac_byte1_reg   <= shift_reg;
            default: begin
            end
         endcase
      end
   end

   // ************************************************************
   // field outputs
   // ************************************************************
   assign o_sda                     = 1'b0;
   assign o_sda_oe                  = sda_low_reg;
   assign o_crystal_margin_offset   = {margin_high_reg, margin_low_reg};
   assign o_diff_buffer_powerdown   = pwrdn_reg;
   assign o_out_sel                 = out_sel_reg;
   assign o_out_div                 = {out_div_high_reg, out_div_low_reg};
   assign o_out_div_reserved        = (o_out_div < OUT_DIV_MIN);
   assign o_reference_div4_enable   = rdiv4_reg;
   assign o_feedback_integer_value  = {fb_int_high_reg, fb_int_low_reg};
   assign o_fraction_numerator_high = {frac_byte2_reg, frac_byte1_reg};

endmodule : odcr_regs
`default_nettype wire

// [verif/odcr_regs_assertions.sv]
`timescale 1ns/1ns
`default_nettype none
module odcr_regs_chk
   import odcr_pkg::*;
(
   input wire logic                 i_clk_sys,
   input wire logic                 i_sys_rst,
   input wire logic                 i_scl,
   input wire logic                 o_sda_oe,
   input wire logic [MARGIN_W-1:0]  o_crystal_margin_offset,
   input wire logic                 o_diff_buffer_powerdown,
   input wire logic [1:0]           o_out_sel,
   input wire logic [OUT_DIV_W-1:0] o_out_div,
   input wire logic                 o_out_div_reserved,
   input wire logic                 o_reference_div4_enable,
   input wire logic [FB_INT_W-1:0]  o_feedback_integer_value,
   input wire logic [FRAC_HI_W-1:0] o_fraction_numerator_high
);
   // ****************
   // checks
   // ****************
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);
   a_margin_reset: assert property ($fell(i_sys_rst) |-> o_crystal_margin_offset == 10'h000)
      else $error("margin offset not at reset value");
   a_pwdn_reset: assert property ($fell(i_sys_rst) |-> !o_diff_buffer_powerdown)
      else $error("powerdown not clear after reset");
   a_osel_reset: assert property ($fell(i_sys_rst) |-> o_out_sel == OUT_SEL_LVPECL)
      else $error("driver select not at reset value");
   a_odiv_reset: assert property ($fell(i_sys_rst) |-> o_out_div == 9'h046)
      else $error("output divider not at reset value");
   a_div4_reset: assert property ($fell(i_sys_rst) |-> !o_reference_div4_enable)
      else $error("reference divide not bypassed after reset");
   a_fbint_reset: assert property ($fell(i_sys_rst) |-> o_feedback_integer_value == 12'h031)
      else $error("feedback divider not at reset value");
   a_frac_reset: assert property ($fell(i_sys_rst) |-> o_fraction_numerator_high == 14'h0001)
      else $error("numerator not at reset value");
   a_rsv_flag: assert property (o_out_div_reserved == (o_out_div inside {[9'h000:9'h004]}))
      else $error("reserved divider flag wrong");
   a_field_update: assert property (($changed(o_out_div) || $changed(o_fraction_numerator_high))
      |-> !$past(i_scl) && !$past(i_scl, 2)) else $error("field changed outside scl low");
   a_oe_hold: assert property ($changed(o_sda_oe) |-> !$past(i_scl) && !$past(i_scl, 2))
      else $error("sda drive changed outside scl low");
   c_ack: cover property ($rose(o_sda_oe));
   c_rsv: cover property ($rose(o_out_div_reserved));
   c_hcsl: cover property (o_out_sel == OUT_SEL_HCSL && o_diff_buffer_powerdown);
endmodule : odcr_regs_chk
bind odcr_regs odcr_regs_chk u_chk (.i_clk_sys, .i_sys_rst, .i_scl, .o_sda_oe,
   .o_crystal_margin_offset, .o_diff_buffer_powerdown, .o_out_sel, .o_out_div,
   .o_out_div_reserved, .o_reference_div4_enable, .o_feedback_integer_value,
   .o_fraction_numerator_high);
`default_nettype wire

// [verif/odcr_host.sv]
`timescale 1ns/1ns
`default_nettype none
module odcr_host (
   input  wire logic i_clk_sys,
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda_low
);
   // ****************
   // serial host
   // ****************
   int ph = 5;
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask : hold
   task automatic start();
      o_sda_low = 1'b0;
      hold(ph);
      o_scl = 1'b1;
      hold(ph);
      o_sda_low = 1'b1;
      hold(ph);
      o_scl = 1'b0;
      hold(ph);
   endtask : start
   task automatic stop();
      o_sda_low = 1'b1;
      hold(ph);
      o_scl = 1'b1;
      hold(ph);
      o_sda_low = 1'b0;
      hold(ph);
   endtask : stop
   task automatic xbyte(input logic [8:0] d, output logic [8:0] q);
      for (int i = 8; i >= 0; i--) begin
         o_sda_low = ~d[i];
         hold(ph);
         o_scl = 1'b1;
         hold(ph);
         q[i] = i_sda;
         o_scl = 1'b0;
         hold(2);
      end
   endtask : xbyte
   task automatic wr(input logic [6:0] a, input logic [7:0] o, input logic [15:0] d,
                     input int n, output logic ok);
      logic [8:0] q;
      start();
      xbyte({a, 2'b01}, q);
      ok = ~q[0];
      xbyte({o, 1'b1}, q);
      for (int i = n - 1; i >= 0; i--) begin // high byte first
         xbyte({d[8*i+:8], 1'b1}, q);
      end
      stop();
   endtask : wr
   task automatic rd(input logic [6:0] a, input logic [7:0] o, output logic [7:0] v);
      logic [8:0] q;
      start();
      xbyte({a, 2'b01}, q);
      xbyte({o, 1'b1}, q);
      start();
      xbyte({a, 2'b11}, q);
      xbyte(9'h1ff, q);
      v = q[8:1];
      stop();
   endtask : rd
endmodule : odcr_host
`default_nettype wire

// [verif/tb_oscillator_divider_config_regs.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_oscillator_divider_config_regs;
   import odcr_pkg::*;
   localparam logic [6:0] ADDR = 7'h5a; // arbitrary bus address
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic scl, sda_low, oe, sdo, pwd, rsv, div4, ok;
   logic [1:0] osel;
   logic [MARGIN_W-1:0] margin;
   logic [OUT_DIV_W-1:0] odiv;
   logic [FB_INT_W-1:0] fb;
   logic [FRAC_HI_W-1:0] frac;
   logic [7:0] mir [16:28];
   logic [7:0] o;
   int mismatches = 0;
   int cmp_count = 0;
   int seed = 32'h6d1b_d895;
   int r;
   wire logic sda = ~(sda_low | (oe & ~sdo));
   always #10 clk = ~clk;
   odcr_host host (.i_clk_sys(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
   odcr_regs #(.DEV_ADDR(ADDR)) dut (.i_clk_sys(clk), .i_sys_rst(rst), .i_scl(scl),
      .i_sda(sda), .o_sda(sdo), .o_sda_oe(oe), .o_crystal_margin_offset(margin),
      .o_diff_buffer_powerdown(pwd), .o_out_sel(osel), .o_out_div(odiv),
      .o_out_div_reserved(rsv), .o_reference_div4_enable(div4),
      .o_feedback_integer_value(fb), .o_fraction_numerator_high(frac));
   // ****************
   // helpers
   // ****************
   function automatic logic [7:0] msk(input logic [7:0] a);
      case (a)
         8'h10: return 8'h03;
         8'h15: return 8'h83;
         8'h16, 8'h18: return 8'h01;
         8'h19: return 8'h0f;
         8'h1b: return 8'h3f;
         8'h11, 8'h17, 8'h1a, 8'h1c: return 8'hff;
         default: return 8'h00;
      endcase
   endfunction : msk
   task automatic wrap_up();
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic init_mir();
      for (int i = 16; i <= 28; i++) mir[i] = 8'h00;
      mir[8'h15] = 8'h01;
      mir[8'h17] = 8'h46;
      mir[8'h1a] = 8'h31;
      mir[8'h1c] = 8'h01;
   endtask : init_mir
   task automatic outs();
      chk("margin", {mir[8'h10][1:0], mir[8'h11]}, margin);
      chk("pwdn", mir[8'h15][7], pwd);
      chk("osel", mir[8'h15][1:0], osel);
      chk("odiv", {mir[8'h16][0], mir[8'h17]}, odiv);
      chk("rsv", {mir[8'h16][0], mir[8'h17]} < 9'h005, rsv);
      chk("div4", mir[8'h18][0], div4);
      chk("fbint", {mir[8'h19][3:0], mir[8'h1a]}, fb);
      chk("frac", {mir[8'h1b][5:0], mir[8'h1c]}, frac);
   endtask : outs
   task automatic put(input logic [7:0] a, input logic [15:0] d, input int n);
      host.wr(ADDR, a, d, n, ok);
      chk("ack", 1'b1, ok);
      for (int i = 0; i < n; i++) mir[a+i] = d[8*(n-1-i)+:8] & msk(a + 8'(i));
      outs();
   endtask : put
   task automatic get(input logic [7:0] a);
      logic [7:0] v;
      host.rd(ADDR, a, v);
      chk("read", mir[a], v);
   endtask : get
   // ****************
   // scenarios
   // ****************
   initial begin
      init_mir();
      repeat (4) @(posedge clk);
      #1;
      rst = 1'b0;
      host.hold(3);
      outs();
      for (int i = 16; i <= 28; i++) get(8'(i));
      repeat (12) begin
         r = $random(seed);
         put(8'h10 + 8'(r[3:0] % 4'hd), {8'h00, r[15:8]}, 1);
         get(8'h10 + 8'(r[3:0] % 4'hd));
      end
      for (int k = 0; k < 4; k++) put(8'h15, {8'h00, 8'(k) << 7 | 8'h7c | 8'(k)}, 1);
      host.ph = 9;
      put(8'h16, 16'h0004, 2);
      put(8'h16, 16'h0005, 2);
      put(8'h16, 16'hfeff, 2);
      host.ph = 4;
      r = $random(seed);
      put(8'h1b, r[15:0] | 16'hc000, 2);
      get(8'h1b);
      put(8'h19, r[31:16], 2);
      put(8'h10, r[31:16], 2);
      host.wr(ADDR ^ 7'h01, 8'h15, 16'h0003, 1, ok);
      chk("nack", 1'b0, ok);
      outs();
      rst = 1'b1;
      host.hold(3);
      rst = 1'b0;
      init_mir();
      host.hold(3);
      outs();
      wrap_up();
   end
   initial begin
      #1_000_000;
      mismatches++;
      wrap_up();
   end
endmodule : tb_oscillator_divider_config_regs
`default_nettype wire
